/* File: include/sfr_defs.svh */
// Constants of the fault-reaction state machine: timing, offsets, reset values.
// Assumes a 125 MHz system clock; included by bare name.
`ifndef SFR_DEFS_SVH
`define SFR_DEFS_SVH
`define SFR_CLK_MHZ 125
`define SFR_FS_MIN_MS 20
`define SFR_FS_TSD_MIN_S 1
`define SFR_FS_REPEAT_MAX 2'h3
`define SFR_RD_STEP_US 10
`define SFR_RD_STEP_CYC (`SFR_RD_STEP_US * `SFR_CLK_MHZ)
`define SFR_HARD_OFF_US 20
`define SFR_HARD_OFF_CYC (`SFR_HARD_OFF_US * `SFR_CLK_MHZ)
`define SFR_STG_US 100
`define SFR_SS2_STEP_US 50
`define SFR_CW 27
`define SFR_AW 8
`define SFR_NSTAY 9
`define SFR_CAUSE_STG 4'hf
`define SFR_OFF_STATUS 8'h00
`define SFR_OFF_FLAGS 8'h04
`define SFR_OFF_STBY_CFG 8'h08
`define SFR_OFF_RD_CFG 8'h0c
`define SFR_OFF_SS2_CFG 8'h10
`define SFR_STBY_CFG_RST 1'h1
`define SFR_RD_CFG_RST 2'h1
`define SFR_SS2_CFG_RST 4'h2
`endif

/* File: include/sfr_pkg.sv */
// Types of the fault-reaction state machine.
// Assumes nothing beyond a SystemVerilog compiler.
package sfr_pkg;
    typedef enum logic [2:0] {
        st_init,
        st_normal,
        st_standby,
        st_failsafe,
        st_powerdown
    } sfr_state_t;
endpackage

/* File: rtl/sfr_fault_fsm.sv */
// Fault reaction of a safety power-management state machine with register port.
// Assumes analog monitor levels arrive asynchronously; command and watchdog pulses are
// from logic on clk_sys.
// Summary of operation
// - Automatic FAILSAFE exit stops after three consecutive entries for one cause.
// - FAILSAFE lasts at least 20 ms, or 1 s after thermal shutdown.
// - Requests to leave FAILSAFE before the dwell ends are ignored.
// - INIT ramps regulators; reset released one delay after rails become valid.
// - Leaving FAILSAFE restores defaults except standby and reset-delay settings.
// - Safe-state outputs stay low in FAILSAFE, STANDBY and the following INIT.
// - Four fault classes; POWERDOWN beats FAILSAFE, which beats INIT.
// - Stay-in-state faults raise an interrupt event and keep the state.
// - Bandgap deviation above 4% is a stay-in-state event.
// - Every stay-in-state event is latched in sticky status flags in any state.
// - Undervoltage, watchdog overflow, error stop or INIT timeout move to INIT.
// - First INIT timeout gives a soft reset with outputs re-enabled.
// - Second INIT timeout gives a hard reset with outputs cycled off.
// - NORMAL to INIT fault pulls reset and the first safe-state output low.
// - Short undervoltage restarts reset delay; long one leads to FAILSAFE.
// - Watchdog or error-pin soft reset times the delay from the reset fall.
// - First safe-state drops with reset, second after its configured delay.
// - Return to NORMAL before that delay keeps the second safe-state high.
// - Standby rail undervoltage in STANDBY enters INIT with power sequence.
// - Internal supply faults give a hard reset in any state except FAILSAFE and POWERDOWN.
`include "sfr_defs.svh"
module sfr_fault_fsm #(
    parameter int FS_MIN_CYC = `SFR_FS_MIN_MS * `SFR_CLK_MHZ * 1000,
    parameter int FS_TSD_CYC = `SFR_FS_TSD_MIN_S * `SFR_CLK_MHZ * 1000000,
    parameter int STG_CYC = `SFR_STG_US * `SFR_CLK_MHZ,
    parameter int SS2_STEP_CYC = `SFR_SS2_STEP_US * `SFR_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [`SFR_AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Analog monitor levels, asynchronous
    input wire logic ctrl_rails_valid,
    input wire logic standby_rail_uv,
    input wire logic fs_fault,
    input wire logic fs_thermal,
    input wire logic [3:0] fs_cause,
    input wire logic pd_fault,
    input wire logic [`SFR_NSTAY-1:0] stay_fault,
    // Monitor and command pulses, clk_sys domain
    input wire logic wd_overflow,
    input wire logic err_stop,
    input wire logic init_timer_exp,
    input wire logic int_supply_fault,
    input wire logic go_normal_req,
    input wire logic go_standby_req,
    input wire logic leave_failsafe_req,
    // Device outputs
    output logic reset_out_pin,
    output logic safe_state_first,
    output logic safe_state_second,
    output logic regulators_en,
    output logic standby_regulator,
    output logic power_seq_start,
    output logic cfg_defaults_load,
    output logic stay_int_event
);
    localparam int NS = `SFR_NSTAY + 9;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic rails_ok, sby_uv, fs_f, fs_tsd, pd_f;
    logic [3:0] cause_s;
    logic [`SFR_NSTAY-1:0] stay_s;
    sfr_pkg::sfr_state_t state_reg;
    logic [`SFR_CW-1:0] dwell_cnt_reg, rd_cnt_reg, hard_cnt_reg, stg_cnt_reg, ss2_cnt_reg;
    logic [3:0] last_cause_reg;
    logic [1:0] fs_count_reg;
    logic fs_tsd_reg, rd_now_reg, hard_off_reg, tmo_seen_reg, ss2_hold_reg;
    logic [`SFR_NSTAY-1:0] flags_reg;
    logic stby_cfg_reg;
    logic [1:0] rd_cfg_reg;
    logic [3:0] ss2_cfg_reg;
    logic dwell_done, fs_blocked, stg_done, go_fs, go_init, init_hard, init_rd_now;
    logic wr_flags;

    // Two-stage synchroniser for every analog level
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {ctrl_rails_valid, standby_rail_uv, fs_fault, fs_thermal,
                          fs_cause, pd_fault, stay_fault};
            sync2_reg <= sync1_reg;
        end
    end
    assign rails_ok = sync2_reg[NS-1];
    assign sby_uv = sync2_reg[NS-2];
    assign fs_f = sync2_reg[NS-3];
    assign fs_tsd = sync2_reg[NS-4];
    assign cause_s = sync2_reg[NS-5:NS-8];
    assign pd_f = sync2_reg[`SFR_NSTAY];
    assign stay_s = sync2_reg[`SFR_NSTAY-1:0];

    function automatic logic [`SFR_CW-1:0] scale(input logic [3:0] sel, input int step);
        scale = `SFR_CW'(({23'h0, sel} + 27'h1) * `SFR_CW'(step));
    endfunction

    // Thermal shutdown lengthens the dwell
    assign dwell_done = dwell_cnt_reg >= (fs_tsd_reg ? `SFR_CW'(FS_TSD_CYC)
                                                     : `SFR_CW'(FS_MIN_CYC));
    assign fs_blocked = fs_count_reg == `SFR_FS_REPEAT_MAX;
    assign stg_done = stg_cnt_reg >= `SFR_CW'(STG_CYC);
    // FAILSAFE class outranks INIT class; POWERDOWN is checked first in the FSM
    assign go_fs = fs_f || stg_done;
    assign init_hard = int_supply_fault || (init_timer_exp && tmo_seen_reg);
    assign init_rd_now = wd_overflow || err_stop;
    always_comb
    begin
        go_init = wd_overflow || err_stop || init_timer_exp || int_supply_fault;
        if (state_reg == sfr_pkg::st_normal && !rails_ok)
            go_init = 1'b1;
        if (state_reg == sfr_pkg::st_standby && sby_uv)
            go_init = 1'b1;
    end

    // Main state machine
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= sfr_pkg::st_init;
            reset_out_pin <= 1'b0;
            regulators_en <= 1'b1;
            hard_off_reg <= 1'b0;
            rd_now_reg <= 1'b0;
            rd_cnt_reg <= '0;
            hard_cnt_reg <= '0;
            dwell_cnt_reg <= '0;
            tmo_seen_reg <= 1'b0;
            power_seq_start <= 1'b0;
            cfg_defaults_load <= 1'b0;
        end
        else
        begin
            power_seq_start <= 1'b0;
            cfg_defaults_load <= 1'b0;
            case (state_reg)
                sfr_pkg::st_failsafe:
                begin
                    dwell_cnt_reg <= dwell_cnt_reg + 27'h1;
                    if (pd_f)
                        state_reg <= sfr_pkg::st_powerdown;
                    // Early leave requests fall through and are lost
                    else if (dwell_done && (!fs_blocked || leave_failsafe_req))
                    begin
                        state_reg <= sfr_pkg::st_init;
                        regulators_en <= 1'b1;
                        power_seq_start <= 1'b1;
                        cfg_defaults_load <= 1'b1;
                        rd_now_reg <= 1'b0;
                        rd_cnt_reg <= '0;
                        tmo_seen_reg <= 1'b0;
                    end
                end
                sfr_pkg::st_powerdown:
                begin
                    regulators_en <= 1'b0;
                    reset_out_pin <= 1'b0;
                end
                default:
                begin
                    if (pd_f)
                    begin
                        state_reg <= sfr_pkg::st_powerdown;
                        regulators_en <= 1'b0;
                        reset_out_pin <= 1'b0;
                    end
                    else if (go_fs)
                    begin
                        state_reg <= sfr_pkg::st_failsafe;
                        regulators_en <= 1'b0;
                        reset_out_pin <= 1'b0;
                        dwell_cnt_reg <= '0;
                    end
                    else if (go_init)
                    begin
                        state_reg <= sfr_pkg::st_init;
                        reset_out_pin <= 1'b0;
                        rd_cnt_reg <= '0;
                        rd_now_reg <= init_rd_now && !init_hard;
                        hard_off_reg <= init_hard;
                        hard_cnt_reg <= '0;
                        regulators_en <= !init_hard;
                        power_seq_start <= !init_hard;
                        if (init_timer_exp)
                            tmo_seen_reg <= 1'b1;
                    end
                    else if (state_reg == sfr_pkg::st_init)
                    begin
                        if (hard_off_reg)
                        begin
                            hard_cnt_reg <= hard_cnt_reg + 27'h1;
                            if (hard_cnt_reg >= `SFR_CW'(`SFR_HARD_OFF_CYC))
                            begin
                                hard_off_reg <= 1'b0;
                                regulators_en <= 1'b1;
                                power_seq_start <= 1'b1;
                            end
                        end
                        else if (!reset_out_pin)
                        begin
                            // Rail dip restarts the delay unless it is timed from the fall
                            if (rails_ok || rd_now_reg)
                                rd_cnt_reg <= rd_cnt_reg + 27'h1;
                            else
                                rd_cnt_reg <= '0;
                            if (rd_cnt_reg >= scale({2'h0, rd_cfg_reg}, `SFR_RD_STEP_CYC))
                                reset_out_pin <= 1'b1;
                        end
                        else if (!rails_ok)
                        begin
                            reset_out_pin <= 1'b0;
                            rd_cnt_reg <= '0;
                            rd_now_reg <= 1'b0;
                        end
                        else if (go_normal_req)
                        begin
                            state_reg <= sfr_pkg::st_normal;
                            tmo_seen_reg <= 1'b0;
                        end
                    end
                    else if (state_reg == sfr_pkg::st_normal && go_standby_req)
                    begin
                        state_reg <= sfr_pkg::st_standby;
                        reset_out_pin <= 1'b0;
                        regulators_en <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Consecutive FAILSAFE entries per cause
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_cause_reg <= 4'h0;
            fs_count_reg <= 2'h0;
            fs_tsd_reg <= 1'b0;
        end
        else if (state_reg != sfr_pkg::st_failsafe && state_reg != sfr_pkg::st_powerdown
                 && !pd_f && go_fs)
        begin
            last_cause_reg <= stg_done && !fs_f ? `SFR_CAUSE_STG : cause_s;
            fs_tsd_reg <= fs_f && fs_tsd;
            if ((stg_done && !fs_f ? `SFR_CAUSE_STG : cause_s) != last_cause_reg)
                fs_count_reg <= 2'h1;
            else if (fs_count_reg != `SFR_FS_REPEAT_MAX)
                fs_count_reg <= fs_count_reg + 2'h1;
        end
    end

    // Short-to-ground timer runs while rails are down with regulators on
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            stg_cnt_reg <= '0;
        else if (regulators_en && !rails_ok && state_reg != sfr_pkg::st_failsafe
                 && state_reg != sfr_pkg::st_standby && state_reg != sfr_pkg::st_powerdown)
            stg_cnt_reg <= stg_done ? stg_cnt_reg : stg_cnt_reg + 27'h1;
        else
            stg_cnt_reg <= '0;
    end

    // Safe-state outputs: high only in NORMAL, second one lags on a fault exit to INIT
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            safe_state_first <= 1'b0;
            safe_state_second <= 1'b0;
            ss2_hold_reg <= 1'b0;
            ss2_cnt_reg <= '0;
        end
        else if (state_reg == sfr_pkg::st_normal && !pd_f && !go_fs && go_init)
        begin
            safe_state_first <= 1'b0;
            ss2_hold_reg <= 1'b1;
            ss2_cnt_reg <= '0;
        end
        else if (state_reg == sfr_pkg::st_normal)
        begin
            safe_state_first <= !(pd_f || go_fs || go_standby_req);
            safe_state_second <= !(pd_f || go_fs || go_standby_req);
            ss2_hold_reg <= 1'b0;
        end
        else if (state_reg == sfr_pkg::st_init && go_normal_req && reset_out_pin
                 && rails_ok && !pd_f && !go_fs && !go_init)
        begin
            safe_state_first <= 1'b1;
            safe_state_second <= 1'b1;
            ss2_hold_reg <= 1'b0;
        end
        else if (state_reg == sfr_pkg::st_init && ss2_hold_reg && !pd_f && !go_fs)
        begin
            ss2_cnt_reg <= ss2_cnt_reg + 27'h1;
            if (ss2_cnt_reg >= scale(ss2_cfg_reg, SS2_STEP_CYC))
            begin
                safe_state_second <= 1'b0;
                ss2_hold_reg <= 1'b0;
            end
        end
        else
        begin
            safe_state_first <= 1'b0;
            safe_state_second <= 1'b0;
            ss2_hold_reg <= 1'b0;
        end
    end

    // Sticky event flags; a new event wins over a clear in the same cycle
    assign wr_flags = reg_wr && reg_addr == `SFR_OFF_FLAGS;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_reg <= '0;
            stay_int_event <= 1'b0;
        end
        else
        begin
            flags_reg <= (flags_reg & ~(wr_flags ? reg_wdata[`SFR_NSTAY-1:0] : '0))
                         | stay_s;
            stay_int_event <= |(stay_s & ~flags_reg);
        end
    end

    // Configuration registers; only the SS2 delay returns to default after FAILSAFE
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stby_cfg_reg <= `SFR_STBY_CFG_RST;
            rd_cfg_reg <= `SFR_RD_CFG_RST;
            ss2_cfg_reg <= `SFR_SS2_CFG_RST;
        end
        else if (cfg_defaults_load)
            ss2_cfg_reg <= `SFR_SS2_CFG_RST;
        else if (reg_wr)
        begin
            if (reg_addr == `SFR_OFF_STBY_CFG)
                stby_cfg_reg <= reg_wdata[0];
            if (reg_addr == `SFR_OFF_RD_CFG)
                rd_cfg_reg <= reg_wdata[1:0];
            if (reg_addr == `SFR_OFF_SS2_CFG)
                ss2_cfg_reg <= reg_wdata[3:0];
        end
    end
    // Standby regulator keeps its setting through every reset kind except rst_n, which loads the default
    assign standby_regulator = stby_cfg_reg;

    // Read data valid in the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (!reg_rd)
            reg_rdata <= '0;
        else
            case (reg_addr)
                `SFR_OFF_STATUS: reg_rdata <= {22'h0, fs_count_reg, last_cause_reg,
                                               reset_out_pin, state_reg};
                `SFR_OFF_FLAGS: reg_rdata <= {23'h0, flags_reg};
                `SFR_OFF_STBY_CFG: reg_rdata <= {31'h0, stby_cfg_reg};
                `SFR_OFF_RD_CFG: reg_rdata <= {30'h0, rd_cfg_reg};
                `SFR_OFF_SS2_CFG: reg_rdata <= {28'h0, ss2_cfg_reg};
                default: reg_rdata <= '0;
            endcase
    end

    a_fs_exit_dwell: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_failsafe && $past(state_reg) == sfr_pkg::st_failsafe
        && $changed(state_reg) == 1'b0 ##1 state_reg == sfr_pkg::st_init
        |-> $past(dwell_done))
        else $error("FAILSAFE left before dwell");
    a_fs_early_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_failsafe && !dwell_done && !pd_f
        |=> state_reg == sfr_pkg::st_failsafe)
        else $error("early FAILSAFE exit");
    a_fs_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_failsafe && fs_blocked && !leave_failsafe_req && !pd_f
        |=> state_reg == sfr_pkg::st_failsafe)
        else $error("blocked FAILSAFE exited by itself");
    a_ss_low_fs: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_failsafe ##1 state_reg != sfr_pkg::st_normal
        |-> !safe_state_first && !safe_state_second)
        else $error("safe state high outside NORMAL");
    a_pd_priority: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pd_f && state_reg != sfr_pkg::st_powerdown |=> state_reg == sfr_pkg::st_powerdown)
        else $error("POWERDOWN not taken first");
    a_init_rst_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_normal && go_init && !go_fs && !pd_f
        |=> !reset_out_pin && !safe_state_first && state_reg == sfr_pkg::st_init)
        else $error("NORMAL to INIT without reset");
    a_ss2_lag: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == sfr_pkg::st_normal && safe_state_second && go_init && !go_fs && !pd_f
        |=> safe_state_second [*2])
        else $error("second safe state dropped early");
    a_hard_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg != sfr_pkg::st_failsafe && state_reg != sfr_pkg::st_powerdown
        && int_supply_fault && !go_fs && !pd_f |=> !regulators_en && hard_off_reg)
        else $error("internal supply fault not hard reset");
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (|stay_s) |=> (flags_reg & $past(stay_s)) == $past(stay_s))
        else $error("event flag lost");
    a_rst_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(reset_out_pin) |-> $past(rd_cnt_reg)
        >= $past(scale({2'h0, rd_cfg_reg}, `SFR_RD_STEP_CYC)))
        else $error("reset released before delay");
endmodule // sfr_fault_fsm

/* File: verif/sfr_mcu_model.sv */
// Model of the supplied controller: asks for NORMAL a few cycles after its reset is released.
// Assumes the device outputs change on clk_sys; enable lets the bench hold the device in INIT.
module sfr_mcu_model #(
    parameter int REQ_DELAY = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Device side
    input wire logic enable,
    input wire logic reset_out_pin,
    output logic go_normal_req
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // One request per reset release; a held reset restarts the count
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            go_normal_req <= 1'b0;
        end
        else
        begin
            go_normal_req <= enable && reset_out_pin && cnt == REQ_DELAY;
            cnt <= !reset_out_pin ? 0 : (cnt <= REQ_DELAY ? cnt + 1 : cnt);
        end
    end
endmodule // sfr_mcu_model

/* File: verif/testbench.sv */
// Self-checking bench of the fault-reaction state machine, with a controller model.
// Assumes short timing parameters; rails follow regulators_en one cycle late.
`include "sfr_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, reg_wr, reg_rd, rails, sb_uv, fs_fault, fs_thermal, pd_fault, mcu_on;
    logic go_req, reset_out_pin, ss1, ss2, reg_en, stby, pseq, cfg_ld, stay_ev, seen;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [3:0] fs_cause;
    logic [8:0] stay;
    logic [5:0] pul;
    int failures, checked;
    int n_pseq = 0;
    int n_cfg = 0;
    // Output pulses are counted mid-cycle, clear of the edge that launches them
    always @(negedge clk_sys)
    begin
        n_pseq += pseq;
        n_cfg += cfg_ld;
    end
    sfr_fault_fsm #(.FS_MIN_CYC(50), .FS_TSD_CYC(200), .STG_CYC(40), .SS2_STEP_CYC(10)) i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctrl_rails_valid(rails),
        .standby_rail_uv(sb_uv), .fs_fault(fs_fault), .fs_thermal(fs_thermal),
        .fs_cause(fs_cause), .pd_fault(pd_fault), .stay_fault(stay), .wd_overflow(pul[0]),
        .err_stop(pul[1]), .init_timer_exp(pul[2]), .int_supply_fault(pul[3]),
        .go_normal_req(go_req), .go_standby_req(pul[4]), .leave_failsafe_req(pul[5]),
        .reset_out_pin(reset_out_pin), .safe_state_first(ss1), .safe_state_second(ss2),
        .regulators_en(reg_en), .standby_regulator(stby), .power_seq_start(pseq),
        .cfg_defaults_load(cfg_ld), .stay_int_event(stay_ev));
    sfr_mcu_model i_mcu (.clk_sys(clk_sys), .rst_n(rst_n), .enable(mcu_on),
        .reset_out_pin(reset_out_pin), .go_normal_req(go_req));
    // Rails come up a cycle after the regulators, so a missing enable shows as undervoltage
    always @(posedge clk_sys) rails <= reg_en;
    task automatic print_verdict();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic pulse(input int b);
        @(posedge clk_sys);
        pul[b] <= 1'b1;
        @(posedge clk_sys);
        pul[b] <= 1'b0;
        #1;
    endtask
    // Bounded poll of the state field; running out ends the run
    task automatic wait_st(input logic [2:0] s, input int n);
        for (int i = 0; i < n; i++)
        begin
            rd(`SFR_OFF_STATUS);
            if (d[2:0] === s)
                return;
        end
        chk("state", {29'h0, s}, {29'h0, d[2:0]});
        print_verdict();
    endtask
    task automatic t_regs();
        rd(`SFR_OFF_STATUS); chk("status", 32'h0, d);
        rd(`SFR_OFF_STBY_CFG); chk("stby", 32'h1, d);
        rd(`SFR_OFF_RD_CFG); chk("rd cfg", 32'h1, d);
        rd(`SFR_OFF_SS2_CFG); chk("ss2 cfg", 32'h2, d);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20); chk("unmapped", 32'h0, d);
        wr(`SFR_OFF_RD_CFG, 32'h0);
        wr(`SFR_OFF_SS2_CFG, 32'hf);
        mcu_on <= 1'b1;
        wait_st(3'h1, 1000);
        chk("ss pins", 32'h3, {30'h0, ss1, ss2});
    endtask
    task automatic t_soft(input int b);
        pulse(b);
        chk("soft pins", 32'h3, {28'h0, reset_out_pin, ss1, ss2, reg_en});
        repeat (150) @(posedge clk_sys);
        #1 chk("ss2 held", 32'h1, {31'h0, ss2});
        repeat (20) @(posedge clk_sys);
        #1 chk("ss2 late", 32'h0, {31'h0, ss2});
        wait_st(3'h1, 1000);
    endtask
    task automatic t_hard(input int b);
        pulse(b);
        repeat (3) @(posedge clk_sys);
        #1 chk("hard off", 32'h0, {30'h0, reg_en, reset_out_pin});
        repeat (2400) @(posedge clk_sys);
        #1 chk("still off", 32'h0, {31'h0, reg_en});
        repeat (200) @(posedge clk_sys);
        #1 chk("back on", 32'h1, {31'h0, reg_en});
    endtask
    task automatic fs_entry(input logic [3:0] c, input logic th);
        fs_cause <= c;
        fs_thermal <= th;
        fs_fault <= 1'b1;
        wait_st(3'h3, 10);
        fs_fault <= 1'b0;
        chk("fs pins", 32'h0, {29'h0, reset_out_pin, ss1, ss2});
        pulse(5);
        rd(`SFR_OFF_STATUS); chk("early leave", 32'h3, {29'h0, d[2:0]});
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, sb_uv, fs_fault, fs_thermal, pd_fault, mcu_on} = '0;
        {reg_addr, reg_wdata, fs_cause, stay, pul, failures, checked} = '0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_soft(0);
        t_soft(1);
        mcu_on <= 1'b0;
        pulse(0);
        pulse(2);
        chk("first timeout", 32'h1, {31'h0, reg_en});
        t_hard(2);
        t_hard(3);
        mcu_on <= 1'b1;
        wait_st(3'h1, 2000);
        stay <= 9'h100;
        seen = 1'b0;
        repeat (8) @(posedge clk_sys) #1 seen |= stay_ev;
        stay <= 9'h0;
        chk("stay event", 32'h1, {31'h0, seen});
        rd(`SFR_OFF_STATUS); chk("stay state", 32'h1, {29'h0, d[2:0]});
        rd(`SFR_OFF_FLAGS); chk("flags", 32'h100, d);
        wr(`SFR_OFF_FLAGS, 32'h100);
        rd(`SFR_OFF_FLAGS); chk("flags clr", 32'h0, d);
        pulse(4);
        wait_st(3'h2, 50);
        sb_uv <= 1'b1;
        wait_st(3'h0, 50);
        sb_uv <= 1'b0;
        chk("sb pins", 32'hc, {28'h0, stby, reg_en, ss1, ss2});
        wait_st(3'h1, 2000);
        fs_entry(4'h5, 1'b1);
        repeat (150) @(posedge clk_sys);
        rd(`SFR_OFF_STATUS); chk("tsd dwell", 32'h3, {29'h0, d[2:0]});
        wait_st(3'h0, 50);
        rd(`SFR_OFF_SS2_CFG); chk("ss2 dflt", 32'h2, d);
        rd(`SFR_OFF_RD_CFG); chk("rd kept", 32'h0, d);
        for (int i = 1; i <= 3; i++)
        begin
            fs_entry(4'h3, 1'b0);
            rd(`SFR_OFF_STATUS); chk("count", i << 8 | 32'h33, d[9:0]);
            repeat (80) @(posedge clk_sys);
            if (i == 3)
            begin
                rd(`SFR_OFF_STATUS); chk("blocked", 32'h3, {29'h0, d[2:0]});
                pulse(5);
            end
            wait_st(3'h0, 40);
        end
        pd_fault <= 1'b1;
        fs_fault <= 1'b1;
        wait_st(3'h4, 10);
        rd(`SFR_OFF_STATUS); chk("priority", 32'h4, {29'h0, d[2:0]});
        chk("seq starts", 32'hb, n_pseq);
        chk("default loads", 32'h4, n_cfg);
        print_verdict();
    end
endmodule // testbench
